// [design/sls_params.svh]
// constants of the stroke limit block: offsets, fields, resets, figures
`ifndef SLS_PARAMS_SVH
`define SLS_PARAMS_SVH
`define SLS_ADDR_CFG 4'h0
`define SLS_ADDR_PINSEL 4'h1
`define SLS_ADDR_STATUS 4'h2
`define SLS_ADDR_IRQ_STAT 4'h3
`define SLS_ADDR_IRQ_MASK 4'h4
`define SLS_ADDR_CTRL 4'h5
`define SLS_ADDR_OVERRUN 4'h6
`define SLS_CFG_SRC 0
`define SLS_CFG_SCOPE 1
`define SLS_CFG_WARN_DIS 2
`define SLS_CFG_AUTO_ON 3
`define SLS_CFG_POLE_DIS 4
`define SLS_CFG_DIR 5
`define SLS_CFG_RESET 6'h00
`define SLS_FUNC_FWD 8'h0A
`define SLS_FUNC_REV 8'h0B
`define SLS_FUNC_DOG 8'h22
`define SLS_OVERRUN_BITS 32'h0000001E
`define SLS_EV_STOP 0
`define SLS_EV_WARN 1
`define SLS_EV_ALARM 2
`endif

// [design/sls_pkg.sv]
// types of the stroke limit block
package sls_pkg;
  typedef struct packed {
    logic [31:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
    logic we;
    logic cyc;
    logic stb;
  } sls_wb_req_t;
  typedef struct packed {
    logic upper;
    logic lower;
    logic dog;
  } sls_limits_t;
  typedef enum logic [2:0] {
    SLS_FREE = 3'b001,
    SLS_STOPPED = 3'b010,
    SLS_ALARM = 3'b100
  } sls_state_t;
endpackage

// [design/sls_source_sel.sv]
// limit source selection and direction mapping
`timescale 1ns/10ps
`include "sls_params.svh"
module sls_source_sel
  import sls_pkg::*;
(
  input wire logic [7:0] pin_i,
  input wire logic [7:0] func_fwd_i,
  input wire logic [7:0] func_rev_i,
  input wire logic [7:0] func_dog_i,
  input wire logic src_ctrl_i,
  input wire logic auto_on_i,
  input wire logic dir_i,
  input wire logic ctrl_upper_travel_limit_i,
  input wire logic ctrl_lower_travel_limit_i,
  input wire logic ctrl_dog_i,
  output sls_limits_t lim_o
);
  // returns the level of the first pin whose selector holds the code
  function automatic logic pick(input logic [7:0] pins,
                                input logic [7:0] f0,
                                input logic [7:0] f1,
                                input logic [7:0] f2,
                                input logic [7:0] code,
                                input logic dflt);
    logic v;
    v = dflt;
    if (f0 == code)
      v = pins[0];
    else if (f1 == code)
      v = pins[1];
    else if (f2 == code)
      v = pins[2];
    return v;
  endfunction
  logic fwd_stroke_end;
  logic rev_stroke_end;
  logic dog;
  always_comb
  begin
    // unassigned stroke end reads open, i.e. limit active (fail safe)
    fwd_stroke_end = pick(pin_i, func_fwd_i, func_rev_i, func_dog_i,
                          `SLS_FUNC_FWD, 1'b0); // R11
    rev_stroke_end = pick(pin_i, func_fwd_i, func_rev_i, func_dog_i,
                          `SLS_FUNC_REV, 1'b0); // R11
    dog = pick(pin_i, func_fwd_i, func_rev_i, func_dog_i,
               `SLS_FUNC_DOG, 1'b0); // R11
    if (auto_on_i)
    begin
      fwd_stroke_end = 1'b1; // R10 R14
      rev_stroke_end = 1'b1; // R10 R14
    end
    if (src_ctrl_i)
    begin
      lim_o.upper = ctrl_upper_travel_limit_i; // R1 R2
      lim_o.lower = ctrl_lower_travel_limit_i; // R1 R2
      lim_o.dog = ctrl_dog_i; // R1
    end
    else if (dir_i)
    begin
      lim_o.upper = rev_stroke_end; // R16
      lim_o.lower = fwd_stroke_end; // R16
      lim_o.dog = dog; // R1
    end
    else
    begin
      lim_o.upper = fwd_stroke_end; // R16
      lim_o.lower = rev_stroke_end; // R16
      lim_o.dog = dog; // R1
    end
  end
endmodule

// [design/sls_overrun.sv]
// position overrun check against the captured stroke end position
`timescale 1ns/10ps
`include "sls_params.svh"
module sls_overrun
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic upper_hit_i,
  input wire logic lower_hit_i,
  input wire logic csp_mode_i,
  input wire logic [31:0] cmd_pos_i,
  output logic overrun_o
);
  logic upper_hit_d_r;
  logic lower_hit_d_r;
  logic [31:0] upper_pos_r;
  logic [31:0] lower_pos_r;
  logic signed [32:0] up_diff;
  logic signed [32:0] lo_diff;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      upper_hit_d_r <= 1'b0;
      lower_hit_d_r <= 1'b0;
      upper_pos_r <= 32'h00000000;
      lower_pos_r <= 32'h00000000;
    end
    else
    begin
      upper_hit_d_r <= upper_hit_i;
      lower_hit_d_r <= lower_hit_i;
      // capture the command position at the moment the end is detected
      if (upper_hit_i && !upper_hit_d_r)
        upper_pos_r <= cmd_pos_i;
      if (lower_hit_i && !lower_hit_d_r)
        lower_pos_r <= cmd_pos_i;
    end
  end
  always_comb
  begin
    up_diff = $signed({cmd_pos_i[31], cmd_pos_i})
              - $signed({upper_pos_r[31], upper_pos_r});
    lo_diff = $signed({lower_pos_r[31], lower_pos_r})
              - $signed({cmd_pos_i[31], cmd_pos_i});
    // compare only while the hit is held and its position is captured
    overrun_o = csp_mode_i &&
      ((upper_hit_i && upper_hit_d_r &&
        up_diff >= $signed({1'b0, `SLS_OVERRUN_BITS})) ||
       (lower_hit_i && lower_hit_d_r &&
        lo_diff >= $signed({1'b0, `SLS_OVERRUN_BITS}))); // R5
  end
endmodule

// [design/sls_stroke_limit.sv]
// stroke limit select and stop block with wishbone registers
`timescale 1ns/10ps
`include "sls_params.svh"
// Operation
// R1: source select 0 takes the own end and dog pins, 1 the controller's.
// R2: the controller sends its increasing-side switch as upper limit.
// R3: the motor is stopped while any selected limit input is off.
// R4: in cyclic position mode the controller stops advancing at an end.
// R5: a command 30 bits past the detected end raises the alarm, drops home.
// R6: cyclic position recovery copies actual to target, checks bit 12.
// R7: cyclic velocity recovery sends velocity away after bit 12 is 0.
// R8: profile, table and jog modes just move away from the limit.
// R9: warning select 0 enables the warning, 1 suppresses it but still stops.
// R10: auto-on (reset 0) forces both stroke end inputs on.
// R11: three pin selectors map devices, defaults 0Ah, 0Bh and 22h.
// R12: scope select 0 keeps limits always active, 1 only in homing mode.
// R13: pole select 0 keeps limits during pole detection, 1 disables them.
// R14: with forced-on ends the motor never stops for a stroke limit; with source select 1 the controller's limits still stop it.
// R15: inputs are normally closed, off means the limit is active.
// R16: direction 1 reports reverse end as upper, forward end as lower.
// R17: the warning holds while an enabled limit is active, then clears.
module sls_stroke_limit
  import sls_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] pin_i,
  input wire logic ctrl_upper_travel_limit_i,
  input wire logic ctrl_lower_travel_limit_i,
  input wire logic ctrl_dog_i,
  input wire logic homing_mode_i,
  input wire logic pole_detect_i,
  input wire logic csp_mode_i,
  input wire logic [31:0] cmd_pos_i,
  output logic upper_travel_limit_o,
  output logic lower_travel_limit_o,
  output logic dog_o,
  output logic motor_stop_o,
  output logic travel_limit_warning_o,
  output logic command_overrun_alarm_o,
  output logic home_erase_o,
  output logic irq_o
);
  sls_wb_req_t req;
  sls_limits_t lim;
  sls_state_t state_r;
  sls_state_t state_nxt;
  logic [5:0] cfg_r;
  logic [7:0] func_fwd_r;
  logic [7:0] func_rev_r;
  logic [7:0] func_dog_r;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_mask_r;
  logic [15:0] overrun_cnt_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic wr;
  logic rd;
  logic [3:0] idx;
  logic limits_on;
  logic upper_hit;
  logic lower_hit;
  logic any_hit;
  logic overrun;
  logic alarm_clr;
  logic [2:0] events;
  logic [2:0] w1c;

  function automatic logic [7:0] lane_wr(input logic [7:0] old,
                                         input logic [7:0] nw,
                                         input logic en);
    return en ? nw : old;
  endfunction

  assign req = '{adr: wb_adr_i, dat: wb_dat_i, sel: wb_sel_i,
                 we: wb_we_i, cyc: wb_cyc_i, stb: wb_stb_i};
  assign idx = req.adr[5:2];
  // one wait state: ack rises the edge after the request, then drops;
  // a write lands at the edge where the master samples that ack
  assign wr = req.cyc && req.stb && req.we && ack_r;
  assign rd = req.cyc && req.stb && !req.we && !ack_r;

  sls_source_sel u_src
  (
    .pin_i(pin_i),
    .func_fwd_i(func_fwd_r),
    .func_rev_i(func_rev_r),
    .func_dog_i(func_dog_r),
    .src_ctrl_i(cfg_r[`SLS_CFG_SRC]),
    .auto_on_i(cfg_r[`SLS_CFG_AUTO_ON]),
    .dir_i(cfg_r[`SLS_CFG_DIR]),
    .ctrl_upper_travel_limit_i(ctrl_upper_travel_limit_i),
    .ctrl_lower_travel_limit_i(ctrl_lower_travel_limit_i),
    .ctrl_dog_i(ctrl_dog_i),
    .lim_o(lim)
  );

  always_comb
  begin
    limits_on = 1'b1;
    if (cfg_r[`SLS_CFG_SCOPE] && !homing_mode_i)
      limits_on = 1'b0; // R12
    if (cfg_r[`SLS_CFG_POLE_DIS] && pole_detect_i)
      limits_on = 1'b0; // R13
    upper_hit = limits_on && !lim.upper; // R15
    lower_hit = limits_on && !lim.lower; // R15
    any_hit = upper_hit || lower_hit; // R3
  end

  sls_overrun u_ovr
  (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .upper_hit_i(upper_hit),
    .lower_hit_i(lower_hit),
    .csp_mode_i(csp_mode_i),
    .cmd_pos_i(cmd_pos_i),
    .overrun_o(overrun)
  );

  assign alarm_clr = wr && idx == `SLS_ADDR_CTRL && req.sel[0]
                     && req.dat[0];

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      SLS_FREE:
        if (overrun)
          state_nxt = SLS_ALARM; // R5
        else if (any_hit)
          state_nxt = SLS_STOPPED; // R3
      SLS_STOPPED:
        if (overrun)
          state_nxt = SLS_ALARM; // R5
        else if (!any_hit)
          state_nxt = SLS_FREE;
      SLS_ALARM:
        // the alarm latches; software clears it once the cause is gone
        if (alarm_clr && !overrun)
          state_nxt = any_hit ? SLS_STOPPED : SLS_FREE;
      default:
        state_nxt = SLS_ALARM;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_r <= SLS_FREE;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      motor_stop_o <= 1'b0;
      travel_limit_warning_o <= 1'b0;
      command_overrun_alarm_o <= 1'b0;
      home_erase_o <= 1'b0;
      upper_travel_limit_o <= 1'b0;
      lower_travel_limit_o <= 1'b0;
      dog_o <= 1'b0;
    end
    else
    begin
      motor_stop_o <= any_hit || state_nxt == SLS_ALARM; // R3 R9 R14
      travel_limit_warning_o <= any_hit
                                && !cfg_r[`SLS_CFG_WARN_DIS]; // R9 R17
      command_overrun_alarm_o <= state_nxt == SLS_ALARM; // R5
      home_erase_o <= state_r != SLS_ALARM
                      && state_nxt == SLS_ALARM; // R5
      upper_travel_limit_o <= lim.upper; // R16
      lower_travel_limit_o <= lim.lower; // R16
      dog_o <= lim.dog;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cfg_r <= `SLS_CFG_RESET; // R10
      func_fwd_r <= `SLS_FUNC_FWD; // R11
      func_rev_r <= `SLS_FUNC_REV; // R11
      func_dog_r <= `SLS_FUNC_DOG; // R11
      irq_mask_r <= 3'h0;
    end
    else if (wr && idx == `SLS_ADDR_CFG && req.sel[0])
      cfg_r <= req.dat[5:0]; // R1 R9 R10 R12 R13 R16
    else if (wr && idx == `SLS_ADDR_PINSEL)
    begin
      func_fwd_r <= lane_wr(func_fwd_r, req.dat[7:0], req.sel[0]);
      func_rev_r <= lane_wr(func_rev_r, req.dat[15:8], req.sel[1]);
      func_dog_r <= lane_wr(func_dog_r, req.dat[23:16], req.sel[2]);
    end
    else if (wr && idx == `SLS_ADDR_IRQ_MASK && req.sel[0])
      irq_mask_r <= req.dat[2:0];
  end

  always_comb
  begin
    events = 3'h0;
    events[`SLS_EV_STOP] = any_hit && !motor_stop_o;
    events[`SLS_EV_WARN] = any_hit && !cfg_r[`SLS_CFG_WARN_DIS]
                           && !travel_limit_warning_o;
    events[`SLS_EV_ALARM] = state_nxt == SLS_ALARM
                            && !command_overrun_alarm_o;
    w1c = (wr && idx == `SLS_ADDR_IRQ_STAT && req.sel[0])
          ? req.dat[2:0] : 3'h0;
  end

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      irq_stat_r <= 3'h0;
    else
      irq_stat_r <= (irq_stat_r & ~w1c) | events;
  end

  assign irq_o = |(irq_stat_r & irq_mask_r);

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      overrun_cnt_r <= 16'h0000;
    else if (home_erase_o && overrun_cnt_r != 16'hFFFF)
      overrun_cnt_r <= overrun_cnt_r + 16'h0001;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end
    else
    begin
      ack_r <= req.cyc && req.stb && !ack_r;
      if (rd)
      begin
        unique case (idx)
          `SLS_ADDR_CFG: dat_r <= {26'h0, cfg_r};
          `SLS_ADDR_PINSEL:
            dat_r <= {8'h00, func_dog_r, func_rev_r, func_fwd_r};
          `SLS_ADDR_STATUS:
            dat_r <= {24'h0, state_r == SLS_ALARM, lim.dog, lim.lower,
                      lim.upper, lower_hit, upper_hit,
                      travel_limit_warning_o, motor_stop_o};
          `SLS_ADDR_IRQ_STAT: dat_r <= {29'h0, irq_stat_r};
          `SLS_ADDR_IRQ_MASK: dat_r <= {29'h0, irq_mask_r};
          `SLS_ADDR_OVERRUN: dat_r <= {16'h0, overrun_cnt_r};
          default: dat_r <= 32'h00000000;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
endmodule

// [sim/sls_ctrl_model.sv]
// motion controller model: position command with its own travel switches
`timescale 1ns/10ps
module sls_ctrl_model #(
  parameter int UP = 100,
  parameter int LO = -100
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic [31:0] load_val_i,
  input wire logic run_i,
  input wire logic obey_i,
  input wire logic back_i,
  output logic [31:0] cmd_pos_o,
  output logic ctrl_upper_o,
  output logic ctrl_lower_o,
  output logic ctrl_dog_o
);
  logic [31:0] pos_r;
  assign cmd_pos_o = pos_r;
  // switches sit on the machine, so they follow the command
  assign ctrl_upper_o = $signed(pos_r) < UP;
  assign ctrl_lower_o = $signed(pos_r) > LO;
  assign ctrl_dog_o = pos_r[3];
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pos_r <= 32'h0;
    else if (load_i)
      pos_r <= load_val_i;
    else if (back_i)
      pos_r <= pos_r - 32'h1;
    else if (run_i && !(obey_i && !ctrl_upper_o))
      pos_r <= pos_r + 32'h1;
  end
endmodule

// [sim/sls_stroke_limit_assertions.sv]
// port-level checker for the stroke limit block
`timescale 1ns/10ps
module sls_stroke_limit_assertions (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic csp_mode_i,
  input wire logic upper_travel_limit_o,
  input wire logic lower_travel_limit_o,
  input wire logic motor_stop_o,
  input wire logic travel_limit_warning_o,
  input wire logic command_overrun_alarm_o,
  input wire logic home_erase_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence erase_s;
    home_erase_o && command_overrun_alarm_o;
  endsequence
  sequence erase_end_s;
    !home_erase_o && command_overrun_alarm_o;
  endsequence
  ack_after_take_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  ack_single_a:
    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  stop_cause_a:
    assert property (motor_stop_o && !command_overrun_alarm_o |->
      !upper_travel_limit_o || !lower_travel_limit_o)
    else $error("stop without an open limit");
  warn_with_stop_a:
    assert property (travel_limit_warning_o |-> motor_stop_o)
    else $error("warning without a stop");
  alarm_stops_a:
    assert property (command_overrun_alarm_o |-> motor_stop_o)
    else $error("alarm without a stop");
  alarm_hold_a:
    assert property (command_overrun_alarm_o && !(wb_cyc_i && wb_stb_i)
      |=> command_overrun_alarm_o)
    else $error("alarm dropped without a clear");
  erase_pulse_a:
    assert property (home_erase_o |-> erase_s ##1 erase_end_s)
    else $error("home erase not a single pulse in alarm");
  alarm_mode_a:
    assert property ($rose(command_overrun_alarm_o) |->
      $past(csp_mode_i) && home_erase_o)
    else $error("alarm outside cyclic position mode");
endmodule
bind sls_stroke_limit sls_stroke_limit_assertions u_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .csp_mode_i(csp_mode_i),
  .upper_travel_limit_o(upper_travel_limit_o),
  .lower_travel_limit_o(lower_travel_limit_o),
  .motor_stop_o(motor_stop_o),
  .travel_limit_warning_o(travel_limit_warning_o),
  .command_overrun_alarm_o(command_overrun_alarm_o),
  .home_erase_o(home_erase_o));

// [sim/testbench.sv]
// self-checking bench for the stroke limit block
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_checks++; \
  if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench;
  localparam int UP = 100;
  logic clk_i = 0, rst_n_i = 0, we = 0, cyc = 0, stb = 0;
  logic homing = 0, pole = 0, csp = 0, load = 0, run = 0, obey = 0;
  logic back = 0, ack, up, lo, dog, stop, warn, alarm, irq, c_up, c_lo;
  logic c_dog, fwd, rev, e_up, e_lo, e_stop, erase;
  logic [31:0] adr = 0, dat = 0, rdat, wdo, lval = 0, cmd, r;
  logic [31:0] xs = 32'h2F61;
  logic [7:0] pin = 8'hFF;
  logic [5:0] cfg;
  int n_mismatch = 0, n_checks = 0, d;
  always #10 clk_i = ~clk_i;
  sls_ctrl_model #(.UP(UP), .LO(-UP)) u_ctrl (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .load_i(load), .load_val_i(lval), .run_i(run),
    .obey_i(obey), .back_i(back), .cmd_pos_o(cmd), .ctrl_upper_o(c_up),
    .ctrl_lower_o(c_lo), .ctrl_dog_o(c_dog));
  sls_stroke_limit DUT (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hF), .wb_we_i(we),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(wdo), .wb_ack_o(ack),
    .pin_i(pin), .ctrl_upper_travel_limit_i(c_up),
    .ctrl_lower_travel_limit_i(c_lo), .ctrl_dog_i(c_dog),
    .homing_mode_i(homing), .pole_detect_i(pole), .csp_mode_i(csp),
    .cmd_pos_i(cmd), .upper_travel_limit_o(up), .lower_travel_limit_o(lo),
    .dog_o(dog), .motor_stop_o(stop), .travel_limit_warning_o(warn),
    .command_overrun_alarm_o(alarm), .home_erase_o(erase), .irq_o(irq));
  function logic [31:0] rnd();
    xs = xs ^ (xs << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
    return xs;
  endfunction
  task automatic wb(input logic w, input logic [3:0] i, input logic [31:0] v);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {26'h0, i, 2'h0};
    dat <= v;
    // only the watchdog ends a wait for ack
    do
      @(posedge clk_i);
    while (ack !== 1'b1);
    rdat = wdo;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] i, input logic [31:0] e, string s);
    wb(1'b0, i, 32'h0);
    `CHK(s, e, rdat)
  endtask
  task summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    summarize();
  end
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(4'h0, 32'h0, "cfg");
    rd(4'h1, 32'h00220B0A, "pinsel");
    rd(4'h7, 32'h0, "unmapped");
    rd(4'h2, 32'h70, "status");
    wb(1'b1, 4'h4, 32'h7);
    pin <= 8'hFE;
    repeat (3) @(posedge clk_i);
    `CHK("irq", 1'b1, irq)
    rd(4'h3, 32'h3, "irq_stat");
    wb(1'b1, 4'h4, 32'h0);
    @(posedge clk_i);
    `CHK("irq_masked", 1'b0, irq)
    pin <= 8'hFF;
    wb(1'b1, 4'h3, 32'h7);
    wb(1'b1, 4'h4, 32'h7);
    rd(4'h3, 32'h0, "stat_clr");
    `CHK("irq_clr", 1'b0, irq)
    wb(1'b1, 4'h1, 32'h00220A0B);
    pin <= 8'hFE;
    repeat (3) @(posedge clk_i);
    `CHK("remap_up", 1'b1, up)
    `CHK("remap_lo", 1'b0, lo)
    wb(1'b1, 4'h1, 32'h00220B0A);
    for (int i = 0; i < 48; i++)
    begin
      r = rnd();
      cfg = r[29:24];
      wb(1'b1, 4'h0, {26'h0, cfg});
      pin <= r[7:0];
      homing <= r[8];
      pole <= r[9];
      load <= 1'b1;
      lval <= {{24{r[23]}}, r[23:16]};
      @(posedge clk_i);
      load <= 1'b0;
      repeat (3) @(posedge clk_i);
      fwd = cfg[3] | pin[0];
      rev = cfg[3] | pin[1];
      e_up = cfg[0] ? c_up : (cfg[5] ? rev : fwd);
      e_lo = cfg[0] ? c_lo : (cfg[5] ? fwd : rev);
      e_stop = (!cfg[1] || homing) && !(pole && cfg[4]) && !(e_up && e_lo);
      `CHK("upper", e_up, up)
      `CHK("lower", e_lo, lo)
      `CHK("dog", cfg[0] ? c_dog : pin[2], dog)
      `CHK("stop", e_stop, stop)
      `CHK("warn", e_stop & !cfg[2], warn)
    end
    wb(1'b1, 4'h0, 32'h1);
    csp <= 1'b1;
    load <= 1'b1;
    lval <= UP - 5;
    @(posedge clk_i);
    load <= 1'b0;
    run <= 1'b1;
    obey <= 1'b1;
    repeat (60) @(posedge clk_i);
    `CHK("no_alarm", 1'b0, alarm)
    `CHK("held_stop", 1'b1, stop)
    obey <= 1'b0;
    for (int n = 0; n < 100 && alarm !== 1'b1; n++) @(posedge clk_i);
    run <= 1'b0;
    d = $signed(cmd) - UP;
    `CHK("erase", 1'b1, erase)
    `CHK("overrun", 1'b1, d >= 30 && d <= 36)
    repeat (5) @(posedge clk_i);
    `CHK("latched", 1'b1, alarm)
    `CHK("erase_end", 1'b0, erase)
    rd(4'h6, 32'h1, "alarm_cnt");
    back <= 1'b1;
    repeat (d + 40) @(posedge clk_i);
    back <= 1'b0;
    wb(1'b1, 4'h5, 32'h1);
    repeat (3) @(posedge clk_i);
    `CHK("alarm_clr", 1'b0, alarm)
    summarize();
  end
endmodule
